// >>> tcs_pkg.sv
/*
 Shared constants for the connector switch-matrix controller: register map,
 field positions, mode codes, switch indices and timing counts.
 Assumes a 10 MHz core clock; all timing counts derive from that period.
*/
// Summary of operation
// - All switches stay open while the enable bit 0x06[4] is low.
// - Once enabled, switch closures follow the three-bit mode field 0x06[2:0].
// - Enable bit resets to one, so the part comes up enabled.
// - Disabled: all open, low current, result register and stored status bits cleared; the overvoltage lockout bit stays live.
// - Every setting of the enable bit restarts the startup sequence.
// - Base modes 001/010: both pairs to hosts, sidebands and senses per mode.
// - Base 000 opens all; 101 data pairs only; 100 adds two sense paths.
// - Base mode 011 takes switches 0-15 from manual registers 0x0d and 0x0e; switches 16-19 stay open.
// - Base 110/111: plus pins to right audio, minus to left; senses per mode.
// - Orientation check off or trigger not 11: plug orientation picks mic side.
// - Serial variant 001: top pair to host1, sidebands fixed, senses to serial.
// - Serial variant codes 010 and 011 both select one default setting.
// - Serial variant 110/111: audio pins, shared ground sense from opposite input.
// - Overvoltage trip opens the protected switches, including sense and serial.
// - CC going high in audio detaches mic/ground sidebands and discharges within 50 us.
// - Serial variant drives an active-low open-drain interrupt request.
// - Path changes open the old side, then close the new after about 10 us.
package tcs_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h15;
	localparam logic [7:0] REG_IMP = 8'h01;
	localparam logic [7:0] REG_STAT = 8'h02;
	localparam logic [7:0] REG_CTRL = 8'h06;
	localparam logic [7:0] REG_MANA = 8'h0d;
	localparam logic [7:0] REG_MANB = 8'h0e;
	localparam int EN_BIT = 4;
	localparam int MODE_HI = 2;
	localparam int MODE_LO = 0;
	localparam logic [7:0] CTRL_RST = 8'h10;
	localparam logic [7:0] CTRL_WMASK = 8'h17;
	localparam logic [7:0] STAT_KEEP = 8'hcf;
	localparam int STAT_READY = 5;
	localparam int STAT_OVERVOLTAGE_LOCKOUT = 4;
	localparam logic [1:0] TRIG_AUTO = 2'h3;
	// Mode codes
	localparam logic [2:0] M_OFF = 3'h0;
	localparam logic [2:0] M_ON_A = 3'h1;
	localparam logic [2:0] M_ON_B = 3'h2;
	localparam logic [2:0] M_MAN = 3'h3;
	localparam logic [2:0] M_SER = 3'h4;
	localparam logic [2:0] M_USB = 3'h5;
	localparam logic [2:0] M_AUD2 = 3'h6;
	localparam logic [2:0] M_AUD1 = 3'h7;
	// ------------------------------------------------------------
	// Switch indices (bit set = switch closed)
	// ------------------------------------------------------------
	localparam int NSW = 20;
	localparam int MAN_HI = 15;
	localparam int SW_TP_H1 = 0, SW_TM_H1 = 1, SW_BP_H2 = 2, SW_BM_H2 = 3;
	localparam int SW_S1_MIC = 8, SW_S1_GND = 9, SW_S2_MIC = 10, SW_S2_GND = 11;
	localparam int SW_LA_GL = 12, SW_RA_GR = 13, SW_LB_GL = 14, SW_RB_GR = 15;
	localparam int SW_RA_TX = 16, SW_RB_RX = 17, SW_RA_RX = 18, SW_RB_TX = 19;
	localparam logic [NSW-1:0] PAIRS = 20'h0000f;
	localparam logic [NSW-1:0] AUDIO = 20'h000f0;
	localparam logic [NSW-1:0] DATA_MASK = 20'h000ff;
	localparam logic [NSW-1:0] SIDE_MASK = 20'hfff00;
	localparam logic [NSW-1:0] SBMG_MASK = 20'h00f00;
	// Synchronised pin indices
	localparam int NSYNC = 6;
	localparam int SY_SCL = 0, SY_SDA = 1, SY_CC = 2, SY_OVD = 3, SY_OVS = 4, SY_ORI = 5;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int T_START_NS = 850000;
	localparam int T_BBM_NS = 10000;
	localparam int T_CC_NS = 50000;
	localparam int START_CYC = (T_START_NS + CLK_NS - 1) / CLK_NS;
	localparam int BBM_CYC = (T_BBM_NS + CLK_NS - 1) / CLK_NS;
	localparam int CC_CYC = T_CC_NS / CLK_NS;
	typedef enum logic [1:0] {ST_OFF = 2'b00, ST_START = 2'b01, ST_READY = 2'b10} tcs_state_t;
	typedef enum logic [2:0] {I_IDLE = 3'b000, I_ADDR = 3'b001, I_RX = 3'b010,
		I_ACK = 3'b011, I_TX = 3'b100, I_MACK = 3'b101} tcs_i2c_st_t;
endpackage

// >>> tcs_i2c_target.sv
/*
 Serial register-port target: start/stop detection, address match, register
 pointer with auto-increment, write strobes and read shifting.
 Assumes scl and sda arrive already synchronised to core_clk.
*/
`timescale 1ns/100ps
module tcs_i2c_target import tcs_pkg::*; (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] rdData,
	output logic sdaOe,
	output logic wrStb,
	output logic rdStb,
	output logic [7:0] regPtr,
	output logic [7:0] accAddr,
	output logic [7:0] wrData
);
	typedef struct packed {
		logic sclD;
		logic sdaD;
		tcs_i2c_st_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic [7:0] wa;
		logic rw;
		logic first;
		logic ackd;
		logic oe;
		logic ws;
		logic rs;
	} tcs_i2c_t;
	tcs_i2c_t r, n;

	// ------------------------------------------------------------
	// Bit engine
	// ------------------------------------------------------------
	always_comb begin
		logic load;
		load = 1'b0;
		n = r;
		n.sclD = scl;
		n.sdaD = sda;
		n.ws = 1'b0;
		n.rs = 1'b0;
		if (r.sclD && scl && r.sdaD && !sda) begin
			n.st = I_ADDR;
			n.cnt = 4'h0;
			n.oe = 1'b0;
		end else if (r.sclD && scl && !r.sdaD && sda) begin
			n.st = I_IDLE;
			n.oe = 1'b0;
		end else if (scl && !r.sclD) begin
			if (r.st == I_ADDR || r.st == I_RX) begin
				n.sh = {r.sh[6:0], sda};
				n.cnt = r.cnt + 4'h1;
			end
			if (r.st == I_MACK) begin
				n.ackd = !sda;
			end
		end else if (!scl && r.sclD) begin
			unique case (r.st)
				I_ADDR: begin
					// Only our own address is acknowledged
					if (r.cnt == 4'h8 && r.sh[7:1] == DEV_ADDR) begin
						n.oe = 1'b1;
						n.rw = r.sh[0];
						n.first = !r.sh[0];
						n.st = I_ACK;
					end else if (r.cnt == 4'h8) begin
						n.st = I_IDLE;
					end
				end
				I_RX: begin
					if (r.cnt == 4'h8) begin
						n.oe = 1'b1;
						n.st = I_ACK;
						n.first = 1'b0;
						if (r.first) begin
							n.ptr = r.sh;
						end else begin
							n.ws = 1'b1;
							n.wa = r.ptr;
							n.ptr = r.ptr + 8'h01;
						end
					end
				end
				I_ACK: begin
					n.oe = 1'b0;
					n.cnt = 4'h0;
					n.st = I_RX;
					load = r.rw;
				end
				I_TX: begin
					n.cnt = r.cnt + 4'h1;
					if (r.cnt == 4'h7) begin
						n.oe = 1'b0;
						n.st = I_MACK;
					end else begin
						n.sh = {r.sh[6:0], 1'b0};
						n.oe = !r.sh[6];
					end
				end
				I_MACK: begin
					// A missing acknowledge ends the read burst
					load = r.ackd;
					n.st = I_IDLE;
				end
				I_IDLE: begin
				end
				default: n.st = I_IDLE;
			endcase
			if (load) begin
				n.sh = rdData;
				n.oe = !rdData[7];
				n.rs = 1'b1;
				n.wa = r.ptr;
				n.ptr = r.ptr + 8'h01;
				n.cnt = 4'h0;
				n.st = I_TX;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign sdaOe = r.oe;
	assign wrStb = r.ws;
	assign rdStb = r.rs;
	assign regPtr = r.ptr;
	assign accAddr = r.wa;
	assign wrData = r.sh;
endmodule

// >>> tcs_switch_ctl.sv
/*
 Switch-matrix controller: register file, startup sequencing, mode routing
 tables for both variants, break-before-make, overvoltage and CC protection.
 Assumes raw pins (serial clock/data, CC, comparators, orientation) are
 asynchronous; detection-engine inputs share core_clk.
*/
`timescale 1ns/100ps
module tcs_switch_ctl import tcs_pkg::*; #(
	parameter bit UART_VARIANT = 1'b0,
	parameter int START_CYCLES = START_CYC,
	parameter int BBM_CYCLES = BBM_CYC
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sclPin,
	input wire logic sdaPin,
	output logic sdaO,
	output logic sdaOe,
	input wire logic ccPin,
	input wire logic ovloDataPin,
	input wire logic ovloSidePin,
	input wire logic plugOrientationPin,
	input wire logic orientationCheckDisable,
	input wire logic [1:0] impedanceTriggerSelect,
	input wire logic detectOrientation,
	input wire logic [7:0] impedanceCode,
	input wire logic impedanceValid,
	input wire logic [7:0] detectFlags,
	output logic [NSW-1:0] switchClose,
	output logic [1:0] sidebandDischarge,
	output logic lowPower,
	output logic intReqNOut,
	output logic intReqNOe
);
	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	if (START_CYCLES < 1 || START_CYCLES > 65535) begin : g_chk_start
		$error("START_CYCLES out of range");
	end
	if (BBM_CYCLES < 1 || BBM_CYCLES > 255) begin : g_chk_bbm
		$error("BBM_CYCLES out of range");
	end

	typedef struct packed {
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic [NSYNC-1:0] s3;
		logic [NSYNC-1:0] cl;
		logic [7:0] ctrl;
		logic [7:0] manA;
		logic [7:0] manB;
		logic [7:0] imp;
		logic [7:0] stat;
		tcs_state_t st;
		logic [15:0] cnt;
		logic [7:0] bbm;
		logic [NSW-1:0] app;
		logic [NSW-1:0] sw;
		logic [1:0] dis;
		logic rdyD;
		logic ovD;
		logic ccD;
		logic irq;
		logic irqOe;
	} tcs_ctl_t;
	localparam tcs_ctl_t RST_VAL = '{ctrl: CTRL_RST, st: ST_OFF, default: '0};
	tcs_ctl_t r, n;

	logic wrStb, rdStb;
	logic [7:0] regPtr, accAddr, wrData, rdData;
	logic [NSW-1:0] tgt, mask;
	logic en, audio, swap, ori, ready, ovAny, ev;
	logic [2:0] mode;

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	tcs_i2c_target u_port (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.scl(r.cl[SY_SCL]),
		.sda(r.cl[SY_SDA]),
		.rdData(rdData),
		.sdaOe(sdaOe),
		.wrStb(wrStb),
		.rdStb(rdStb),
		.regPtr(regPtr),
		.accAddr(accAddr),
		.wrData(wrData)
	);
	assign sdaO = 1'b0; // Open drain: only ever pulls low

	// Readback; unmapped addresses and reserved bits read zero
	always_comb begin
		unique case (regPtr)
			REG_IMP: rdData = r.imp;
			REG_STAT: begin
				rdData = r.stat;
				rdData[STAT_READY] = ready;
				rdData[STAT_OVERVOLTAGE_LOCKOUT] = ovAny;
			end
			REG_CTRL: rdData = r.ctrl;
			REG_MANA: rdData = r.manA;
			REG_MANB: rdData = r.manB;
			default: rdData = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Decoded control
	// ------------------------------------------------------------
	assign en = r.ctrl[EN_BIT];
	assign mode = r.ctrl[MODE_HI:MODE_LO];
	assign audio = (mode == M_AUD2) || (mode == M_AUD1);
	assign ori = r.cl[SY_ORI];
	assign ready = (r.st == ST_READY);
	assign ovAny = r.cl[SY_OVD] | r.cl[SY_OVS];
	// Without the automatic check, the plug orientation alone decides the mic side
	assign swap = (orientationCheckDisable || impedanceTriggerSelect != TRIG_AUTO) ?
		ori : detectOrientation;

	// ------------------------------------------------------------
	// Routing tables
	// ------------------------------------------------------------
	always_comb begin
		tgt = '0;
		if (!UART_VARIANT) begin
			unique case (mode)
				M_OFF: tgt = '0;
				M_ON_A: begin
					tgt = PAIRS;
					tgt[SW_S1_MIC] = 1'b1;
					tgt[SW_S2_GND] = 1'b1;
					tgt[SW_LB_GL] = 1'b1;
					tgt[SW_RB_GR] = 1'b1;
				end
				M_ON_B: begin
					tgt = PAIRS;
					tgt[SW_S1_GND] = 1'b1;
					tgt[SW_S2_MIC] = 1'b1;
					tgt[SW_LA_GL] = 1'b1;
					tgt[SW_RA_GR] = 1'b1;
				end
				M_MAN: tgt[MAN_HI:0] = {r.manB, r.manA};
				M_SER: begin
					tgt = PAIRS;
					tgt[SW_RA_GR] = 1'b1;
					tgt[SW_LB_GL] = 1'b1;
				end
				M_USB: tgt = PAIRS;
				M_AUD2, M_AUD1: begin
					tgt = AUDIO;
					tgt[SW_S1_MIC] = !swap;
					tgt[SW_S2_GND] = !swap;
					tgt[SW_S1_GND] = swap;
					tgt[SW_S2_MIC] = swap;
					tgt[SW_LB_GL] = !swap;
					tgt[SW_LA_GL] = swap;
					// Single ground sense leaves the right sense paths open
					tgt[SW_RB_GR] = !swap && mode == M_AUD2;
					tgt[SW_RA_GR] = swap && mode == M_AUD2;
				end
			endcase
		end else begin
			unique case (mode)
				M_OFF: tgt = '0;
				M_ON_B, M_MAN: tgt = '0;
				M_ON_A: begin
					tgt[SW_TP_H1] = 1'b1;
					tgt[SW_TM_H1] = 1'b1;
					tgt[SW_S1_MIC] = 1'b1;
					tgt[SW_S2_GND] = 1'b1;
					tgt[SW_RA_TX] = 1'b1;
					tgt[SW_RB_RX] = 1'b1;
				end
				M_SER, M_USB: begin
					tgt[SW_TP_H1] = (mode == M_SER);
					tgt[SW_TM_H1] = (mode == M_SER);
					tgt[SW_BP_H2] = (mode == M_USB);
					tgt[SW_BM_H2] = (mode == M_USB);
					tgt[SW_RA_TX] = !ori;
					tgt[SW_RB_RX] = !ori;
					tgt[SW_RA_RX] = ori;
					tgt[SW_RB_TX] = ori;
				end
				M_AUD2, M_AUD1: begin
					tgt = AUDIO;
					tgt[SW_S1_MIC] = !swap;
					tgt[SW_S2_GND] = !swap;
					tgt[SW_S1_GND] = swap;
					tgt[SW_S2_MIC] = swap;
					tgt[SW_RB_GR] = !swap;
					tgt[SW_RA_GR] = swap;
				end
			endcase
		end
	end

	// Protection masks act at once, bypassing the break-before-make pacing
	always_comb begin
		mask = '0;
		if (r.cl[SY_OVD]) begin
			mask = mask | DATA_MASK;
		end
		if (r.cl[SY_OVS]) begin
			mask = mask | SIDE_MASK;
		end
		if (r.cl[SY_CC] && audio) begin
			mask = mask | SBMG_MASK;
		end
	end

	assign ev = (ready && !r.rdyD) || (ovAny && !r.ovD) || (r.cl[SY_CC] && !r.ccD);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		// Three-stage pin synchronisers; a level counts once stages two and three agree
		n.s1 = {plugOrientationPin, ovloSidePin, ovloDataPin, ccPin, sdaPin, sclPin};
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.cl = (r.s2 & r.s3) | (r.cl & (r.s2 | r.s3));
		// Register writes
		if (wrStb) begin
			unique case (accAddr)
				REG_CTRL: n.ctrl = wrData & CTRL_WMASK;
				REG_MANA: n.manA = wrData;
				REG_MANB: n.manB = wrData;
				default: n.ctrl = r.ctrl;
			endcase
		end
		// Startup sequencer
		unique case (r.st)
			ST_OFF: begin
				if (en) begin
					n.st = ST_START;
					n.cnt = 16'(START_CYCLES - 1);
				end
			end
			ST_START: begin
				if (!en) begin
					n.st = ST_OFF;
				end else if (r.cnt == 16'h0000) begin
					n.st = ST_READY;
				end else begin
					n.cnt = r.cnt - 16'h0001;
				end
			end
			ST_READY: begin
				if (!en) begin
					n.st = ST_OFF;
				end
			end
			default: n.st = ST_OFF;
		endcase
		// Any write that sets the enable bit restarts the sequence
		if (wrStb && accAddr == REG_CTRL && wrData[EN_BIT]) begin
			n.st = ST_START;
			n.cnt = 16'(START_CYCLES - 1);
		end
		// Result and status registers are cleared while disabled
		if (!en) begin
			n.imp = 8'h00;
			n.stat = 8'h00;
		end else if (impedanceValid) begin
			n.imp = impedanceCode;
			n.stat = detectFlags & STAT_KEEP;
		end
		// Break-before-make: openings first, closings only after the gap
		// Disable opens at once; tables alone would hold the paths for one cycle
		if (!ready || !en) begin
			n.app = '0;
			n.bbm = 8'h00;
		end else if ((r.app & ~tgt) != '0) begin
			n.app = r.app & tgt;
			n.bbm = 8'(BBM_CYCLES - 1);
		end else if (r.bbm != 8'h00) begin
			n.bbm = r.bbm - 8'h01;
		end else begin
			n.app = tgt;
		end
		n.sw = n.app & ~mask;
		n.dis = (r.cl[SY_CC] && audio && en) ? 2'b11 : 2'b00;
		// Event flag; a new event in the clearing read's cycle wins
		n.rdyD = ready;
		n.ovD = ovAny;
		n.ccD = r.cl[SY_CC];
		if (rdStb && accAddr == REG_STAT) begin
			n.irq = 1'b0;
		end
		if (ev) begin
			n.irq = 1'b1;
		end
		n.irqOe = UART_VARIANT && n.irq;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= RST_VAL;
		end else begin
			r <= n;
		end
	end

	assign switchClose = r.sw;
	assign sidebandDischarge = r.dis;
	assign lowPower = !en;
	assign intReqNOut = 1'b0;
	assign intReqNOe = r.irqOe;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	localparam int CcLim = CC_CYC;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_off_open: assert property (!en |=> switchClose == '0)
		else $error("switch closed while disabled");
	a_mode_follow: assert property ($rose(ready) |-> ##[1:300] (r.app == tgt))
		else $error("switches did not follow mode");
	a_reset_enabled: assert property ($past(sys_rst) |-> en)
		else $error("enable bit not set after reset");
	a_off_clear: assert property (!en |=> r.imp == 8'h00 && (r.stat & STAT_KEEP) == 8'h00)
		else $error("status not cleared while disabled");
	a_enable_restart: assert property ($rose(en) |=> r.st == ST_START)
		else $error("startup not restarted on enable");
	a_usb_route: assert property (!UART_VARIANT && mode == M_USB |-> tgt == PAIRS)
		else $error("usb mode routes wrong paths");
	a_ser_default: assert property (UART_VARIANT && mode[2:1] == 2'b01 |-> tgt == '0)
		else $error("serial default codes differ");
	a_overvoltage_lockout_open: assert property (r.cl[SY_OVS] |=> switchClose[NSW-1:8] == '0)
		else $error("protected switch closed during overvoltage");
	a_cc_discharge: assert property ($rose(r.cl[SY_CC]) && audio && en
		|-> ##[1:CcLim] sidebandDischarge == 2'b11 && switchClose[11:8] == 4'h0)
		else $error("sideband not discharged after cc");
	a_irq_drive: assert property (UART_VARIANT && ev |=> intReqNOe)
		else $error("interrupt not driven on event");
	a_bbm_gap: assert property (r.bbm != 8'h00 |=> (r.app & ~$past(r.app)) == '0)
		else $error("switch closed inside break gap");

	c_ready: cover property ($rose(ready));
	c_bbm: cover property (r.bbm == 8'h01 ##1 r.bbm == 8'h00);
	c_cc: cover property ($rose(sidebandDischarge[0]));
	c_write: cover property (wrStb && accAddr == REG_CTRL);
endmodule

// >>> tcs_host_model.sv
/*
 Host processor model: drives the two-wire register port as bus master.
 Assumes the bench resolves the open-drain data wire and feeds it back.
*/
`timescale 1ns/100ps
module tcs_host_model import tcs_pkg::*; #(
	parameter int Q = 8
) (
	input wire logic core_clk,
	input wire logic sdaWire,
	output logic scl,
	output logic sdaLow
);
	// Idle bus: clock high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Data moves only mid-low, so the target never sees a false start
	task automatic clk_bit(input logic b, output logic s);
		tick(Q);
		sdaLow = ~b;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		s = sdaWire;
		tick(Q);
		scl = 1'b0;
	endtask
	// Also serves as repeated start when the clock is low
	task automatic start;
		tick(Q);
		sdaLow = 1'b0;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		sdaLow = 1'b1;
		tick(Q);
		scl = 1'b0;
	endtask
	task automatic stop;
		tick(Q);
		sdaLow = 1'b1;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		sdaLow = 1'b0;
		tick(Q);
	endtask
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
		end
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic k0, k1, k2;
		start();
		byte_out({DEV_ADDR, 1'b0}, k0);
		byte_out(a, k1);
		byte_out(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask
	// Single-byte read closed by a not-acknowledge
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic k0, k1, k2, s;
		start();
		byte_out({DEV_ADDR, 1'b0}, k0);
		byte_out(a, k1);
		start();
		byte_out({DEV_ADDR, 1'b1}, k2);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, d[i]);
		end
		clk_bit(1'b1, s);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule

// >>> typec_audio_switch_matrix_ctl_tb_top.sv
/*
 Self-checking bench: base and serial variants share one register bus.
 Assumes the host model for bus cycles and short start/break counts.
*/
`timescale 1ns/100ps
`define TCS_CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module typec_audio_switch_matrix_ctl_tb_top import tcs_pkg::*;;
	localparam int START = 200;
	localparam int WAITC = START + 40;
	logic core_clk, sys_rst, ccPin, ovloD, ovloS;
	logic plugOri, chkDis, detOri, impValid, ok;
	logic [1:0] trigSel, dis1, dis2;
	logic [7:0] impCode, flags, rd, code, ma, mb, junk;
	logic [19:0] sw1, sw2;
	logic [2:0] mode;
	logic oa;
	logic scl, hostLow, oe1, oe2, lp1, lp2, irqOe1, irqOe2, irqN2;
	wire sdaWire = ~(hostLow | oe1 | oe2);
	integer seed, fail_count = 0, tests_run = 0;
	// Clock: 100 ns period
	always #50 core_clk = ~core_clk;
	tcs_host_model u_host (.core_clk(core_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(hostLow));
	tcs_switch_ctl #(.UART_VARIANT(1'b0), .START_CYCLES(START), .BBM_CYCLES(4)) u_dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .sclPin(scl), .sdaPin(sdaWire), .sdaO(),
		.sdaOe(oe1), .ccPin(ccPin), .ovloDataPin(ovloD), .ovloSidePin(ovloS),
		.plugOrientationPin(plugOri), .orientationCheckDisable(chkDis),
		.impedanceTriggerSelect(trigSel), .detectOrientation(detOri), .impedanceCode(impCode),
		.impedanceValid(impValid), .detectFlags(flags), .switchClose(sw1),
		.sidebandDischarge(dis1), .lowPower(lp1), .intReqNOut(), .intReqNOe(irqOe1));
	tcs_switch_ctl #(.UART_VARIANT(1'b1), .START_CYCLES(START), .BBM_CYCLES(4)) u_dut2 (
		.core_clk(core_clk), .sys_rst(sys_rst), .sclPin(scl), .sdaPin(sdaWire), .sdaO(),
		.sdaOe(oe2), .ccPin(ccPin), .ovloDataPin(ovloD), .ovloSidePin(ovloS),
		.plugOrientationPin(plugOri), .orientationCheckDisable(chkDis),
		.impedanceTriggerSelect(trigSel), .detectOrientation(detOri), .impedanceCode(impCode),
		.impedanceValid(impValid), .detectFlags(flags), .switchClose(sw2),
		.sidebandDischarge(dis2), .lowPower(lp2), .intReqNOut(irqN2), .intReqNOe(irqOe2));
	// ------------------------------------------------------------
	// Expected routing per variant
	// ------------------------------------------------------------
	function automatic logic [19:0] exp_base(input logic [2:0] m, input logic o);
		case (m)
			3'h1: return 20'h0c90f;
			3'h2: return 20'h0360f;
			3'h3: return {4'h0, mb, ma};
			3'h4: return 20'h0600f;
			3'h5: return 20'h0000f;
			3'h6: return o ? 20'h036f0 : 20'h0c9f0;
			3'h7: return o ? 20'h016f0 : 20'h049f0;
			default: return 20'h00000;
		endcase
	endfunction
	// Serial paths follow the plug; audio sidebands follow the resolved side a
	function automatic logic [19:0] exp_uart(input logic [2:0] m, input logic o,
		input logic a);
		case (m)
			3'h1: return 20'h30903;
			3'h4: return o ? 20'hc0003 : 20'h30003;
			3'h5: return o ? 20'hc000c : 20'h3000c;
			3'h6, 3'h7: return a ? 20'h026f0 : 20'h089f0;
			default: return 20'h00000;
		endcase
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.write_reg(a, d, ok);
		`TCS_CHK(ok, 1'b1)
	endtask
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Hang guard: counts as a mismatch
	initial begin
		repeat (95000) @(posedge core_clk);
		`TCS_CHK(1'b0, 1'b1)
		final_report();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		// Idle levels at time zero; reset asserted
		core_clk = 1'b0;
		sys_rst = 1'b1;
		ccPin = 1'b0;
		ovloD = 1'b0;
		ovloS = 1'b0;
		plugOri = 1'b0;
		chkDis = 1'b1;
		detOri = 1'b0;
		impValid = 1'b0;
		trigSel = 2'h0;
		impCode = 8'h00;
		flags = 8'h00;
		seed = 32'hbd24a43c;
		repeat (20) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		`TCS_CHK(sw1, 20'h0)
		u_host.read_reg(REG_CTRL, rd, ok);
		`TCS_CHK(rd, 8'h10)
		`TCS_CHK({irqOe2, irqN2, irqOe1}, 3'b100)
		u_host.read_reg(REG_STAT, rd, ok);
		u_host.tick(5);
		`TCS_CHK(irqOe2, 1'b0)
		$display("reset and interrupt test done");
		// Result capture, read-only and unmapped places
		code = $random(seed);
		impCode = code;
		flags = $random(seed);
		impValid = 1'b1;
		u_host.tick(1);
		impValid = 1'b0;
		wr(REG_IMP, ~code);
		u_host.read_reg(REG_IMP, rd, ok);
		`TCS_CHK(rd, code)
		u_host.read_reg(8'h20, rd, ok);
		`TCS_CHK(rd, 8'h00)
		// Disable clears results and opens everything
		wr(REG_CTRL, 8'h05);
		u_host.tick(5);
		`TCS_CHK({sw1, sw2, lp1, lp2}, 42'h3)
		u_host.read_reg(REG_IMP, rd, ok);
		`TCS_CHK(rd, 8'h00)
		u_host.read_reg(REG_STAT, rd, ok);
		`TCS_CHK(rd & 8'hcf, 8'h00)
		$display("disable test done");
		// Every mode in both orientations, junk in reserved bits
		for (int i = 0; i < 16; i++) begin
			mode = i[2:0];
			ma = $random(seed);
			mb = $random(seed);
			junk = $random(seed);
			if (mode == 3'h3) begin
				wr(REG_MANA, ma);
				wr(REG_MANB, mb);
			end
			plugOri = i[3];
			detOri = ~i[3];
			chkDis = junk[3];
			trigSel = junk[6:5];
			// Plug decides unless the check is on and the trigger is automatic
			oa = (junk[3] || junk[6:5] != 2'b11) ? i[3] : ~i[3];
			wr(REG_CTRL, {junk[7:5], 1'b1, junk[3], mode});
			`TCS_CHK({sw1, sw2, lp1}, 41'h0)
			u_host.tick(WAITC);
			`TCS_CHK(sw1, exp_base(mode, oa))
			`TCS_CHK(sw2, exp_uart(mode, i[3], oa))
			u_host.read_reg(REG_CTRL, rd, ok);
			`TCS_CHK(rd, {5'h02, mode})
		end
		$display("mode table test done");
		// Overvoltage on the side paths, then on the data pairs
		wr(REG_CTRL, 8'h11);
		u_host.tick(WAITC);
		ovloS = 1'b1;
		u_host.tick(10);
		`TCS_CHK(sw1, 20'h0000f)
		`TCS_CHK(sw2, 20'h00003)
		u_host.read_reg(REG_STAT, rd, ok);
		`TCS_CHK(rd[STAT_OVERVOLTAGE_LOCKOUT], 1'b1)
		ovloD = 1'b1;
		u_host.tick(10);
		`TCS_CHK({sw1, sw2}, 40'h0)
		ovloS = 1'b0;
		ovloD = 1'b0;
		u_host.tick(20);
		`TCS_CHK(sw1, 20'h0c90f)
		$display("overvoltage test done");
		// Accessory removal in audio mode
		plugOri = 1'b0;
		chkDis = 1'b1;
		wr(REG_CTRL, 8'h16);
		u_host.tick(WAITC);
		// Orientation flip: old side opens, new side closes after the gap
		plugOri = 1'b1;
		u_host.tick(6);
		`TCS_CHK({sw1, sw2}, {20'h000f0, 20'h000f0})
		u_host.tick(4);
		`TCS_CHK({sw1, sw2}, {exp_base(3'h6, 1'b1), exp_uart(3'h6, 1'b1, 1'b1)})
		ccPin = 1'b1;
		u_host.tick(20);
		`TCS_CHK({dis1, dis2}, 4'hf)
		`TCS_CHK({sw1 & SBMG_MASK, sw2 & SBMG_MASK}, 40'h0)
		ccPin = 1'b0;
		u_host.tick(20);
		$display("accessory removal test done");
		final_report();
	end
endmodule
